// *** logic/flash_ctrl_pkg.sv ***
// shared constants, types and state records of the flash sequencer
package flash_ctrl_pkg;

    // ------------------------------------------------------------
    // array organisation
    // ------------------------------------------------------------
    localparam int unsigned FLASH_BYTES     = 8192;
    localparam int unsigned PAGE_COUNT      = 16;
    localparam int unsigned PAGE_BYTES      = 512;
    localparam int unsigned ROWS_PER_PAGE   = 8;
    localparam int unsigned ROW_BYTES       = 64;
    localparam int unsigned SECTOR_COUNT    = 8;
    localparam int unsigned SECTOR_BYTES    = 1024;
    localparam int unsigned OPTION_BYTES    = 2;
    localparam logic [15:0] PROG_FIRST      = 16'h0000;
    localparam logic [15:0] PROG_LAST       = 16'h1FFF;
    localparam logic [15:0] INFO_FIRST      = 16'hFE00;
    localparam logic [15:0] INFO_LAST       = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

    // address field positions
    localparam int unsigned ROW_LSB         = 6;
    localparam int unsigned PAGE_LSB        = 9;
    localparam int unsigned SECTOR_LSB      = 10;

    // ------------------------------------------------------------
    // control codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_KEY_FIRST   = 8'h73;
    localparam logic [7:0]  CMD_KEY_SECOND  = 8'h8C;
    localparam logic [7:0]  CMD_KEY_SECTOR  = 8'h5E;
    localparam logic [7:0]  CMD_PAGE_ERASE  = 8'h95;
    localparam logic [7:0]  CMD_MASS_ERASE  = 8'h63;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [15:0] KHZ_MIN         = 16'h0020;
    localparam logic [15:0] KHZ_MAX         = 16'h4E20;
    localparam logic [31:0] US_PER_MS       = 32'h0000_03E8;
    localparam int unsigned PROG_TIME_US    = 40;
    localparam int unsigned PAGE_ERASE_US   = 10000;
    localparam int unsigned MASS_ERASE_US   = 20000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] KHZ_RESET       = 16'h0000;
    localparam logic [7:0]  PROTECT_RESET   = 8'h00;
    localparam logic [3:0]  PAGE_RESET      = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SEL_CONTROL, SEL_PAGE, SEL_KHZ_HIGH, SEL_KHZ_LOW} reg_sel_type;

    typedef enum logic [2:0] {
        ST_LOCKED, ST_PAGE_SET, ST_KEY_ONE, ST_KEY_TWO, ST_SECTOR_WR, ST_UNLOCKED, ST_BUSY
    } ctrl_state_type;

    typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_PAGE_ERASE, OP_MASS_ERASE} op_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [2:0]  row;
        logic        info;
        logic        option;
        logic [7:0]  wdata;
        logic        rd;
        logic        prog;
        logic        page_erase;
        logic        mass_erase;
    } arr_cmd_type;

    typedef struct packed {
        logic        in_prog;
        logic        in_info;
        logic        option;
        logic [3:0]  page;
        logic [2:0]  sector;
        logic [2:0]  row;
    } addr_info_type;

    typedef struct packed {
        ctrl_state_type state;
        op_type         op;
        logic [3:0]     page;
        logic [15:0]    khz;
        logic [7:0]     protect;
        logic           rd_pend;
        logic           rd_blank;
        logic           rvalid;
        logic [7:0]     rdata;
        arr_cmd_type    cmd;
    } ctrl_reg_type;

    typedef struct packed {
        logic        running;
        logic        done;
        logic [31:0] elapsed;
        logic [31:0] target;
    } timer_reg_type;

endpackage

// *** logic/flash_addr_decode.sv ***
// address decoder: region, page, sector, row and option-byte flags
`timescale 1ns/10ps

module flash_addr_decode
(
    input  wire logic [15:0]                  addr_in,
    output flash_ctrl_pkg::addr_info_type     info_out
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb
    begin
        info_out.in_prog = (addr_in <= flash_ctrl_pkg::PROG_LAST);
        info_out.in_info = (addr_in >= flash_ctrl_pkg::INFO_FIRST);
        info_out.option  = (addr_in < 16'(flash_ctrl_pkg::OPTION_BYTES));
        info_out.page    = addr_in[flash_ctrl_pkg::PAGE_LSB +: 4];
        info_out.sector  = addr_in[flash_ctrl_pkg::SECTOR_LSB +: 3];
        info_out.row     = addr_in[flash_ctrl_pkg::ROW_LSB +: 3];
    end

endmodule

// *** logic/flash_pulse_timer.sv ***
// pulse timer whose length in microseconds is scaled by the clock rate in kHz
`timescale 1ns/10ps

module flash_pulse_timer
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        start_in,
    input  wire logic [15:0] dur_us_in,
    input  wire logic [15:0] khz_in,
    output logic             done_out
);

    flash_ctrl_pkg::timer_reg_type q, d;

    // ------------------------------------------------------------
    // elapsed time kept as cycles times 1000, target as us times kHz;
    // exact at any rate, no divider remainder to drift
    // ------------------------------------------------------------
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        if (start_in)
        begin
            d.running = 1'b1;
            d.elapsed = 32'h0000_0000;
            d.target  = 32'(dur_us_in) * 32'(khz_in);
        end
        else if (q.running)
        begin
            d.elapsed = q.elapsed + flash_ctrl_pkg::US_PER_MS;
            if (d.elapsed >= q.target)
            begin
                d.running = 1'b0;
                d.done    = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign done_out = q.done;

endmodule

// *** logic/flash_array_timing_ctrl.sv ***
// flash sequencer: lock keys, protection, array strobes and pulse timing
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps

module flash_array_timing_ctrl
#(
    parameter int unsigned PROG_US       = flash_ctrl_pkg::PROG_TIME_US,
    parameter int unsigned PAGE_ERASE_US = flash_ctrl_pkg::PAGE_ERASE_US,
    parameter int unsigned MASS_ERASE_US = flash_ctrl_pkg::MASS_ERASE_US
)
(
    input  wire logic                         core_clk_in,
    input  wire logic                         rst_in,
    input  wire logic                         reg_wr_in,
    input  wire flash_ctrl_pkg::reg_sel_type  reg_sel_in,
    input  wire logic [7:0]                   reg_wdata_in,
    input  wire logic                         dbg_mode_in,
    input  wire logic                         write_allow_in,
    input  wire flash_ctrl_pkg::mem_req_type  mem_req_in,
    output logic                              mem_ready_out,
    output logic                              mem_rvalid_out,
    output logic [7:0]                        mem_rdata_out,
    output logic [15:0]                       flash_clock_khz_out,
    output logic                              locked_out,
    output logic                              busy_out,
    output logic [7:0]                        sector_protect_out,
    output flash_ctrl_pkg::arr_cmd_type       arr_cmd_out,
    input  wire logic [7:0]                   arr_rdata_in
);

    flash_ctrl_pkg::ctrl_reg_type  q, d;
    flash_ctrl_pkg::addr_info_type ainfo;
    logic                          khz_ok;
    logic                          page_open;
    logic                          timer_start;
    logic                          timer_done;
    logic [15:0]                   timer_dur;
    logic                          reg_take;
    logic                          mem_take;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    flash_addr_decode u_decode
    (
        .addr_in  (mem_req_in.addr),
        .info_out (ainfo)
    );

    flash_pulse_timer u_timer
    (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .start_in    (timer_start),
        .dur_us_in   (timer_dur),
        .khz_in      (q.khz),
        .done_out    (timer_done)
    );

    // a zero or out-of-range rate would give nonsense pulse lengths
    assign khz_ok    = (q.khz >= flash_ctrl_pkg::KHZ_MIN) &&
                       (q.khz <= flash_ctrl_pkg::KHZ_MAX);
    assign page_open = khz_ok && write_allow_in && !q.protect[q.page[3:1]];
    assign reg_take  = reg_wr_in && (q.state != flash_ctrl_pkg::ST_BUSY);
    assign mem_ready_out = (q.state != flash_ctrl_pkg::ST_BUSY) && !q.rd_pend && !reg_wr_in;
    assign mem_take  = mem_req_in.valid && mem_ready_out;
    assign timer_start = (d.state == flash_ctrl_pkg::ST_BUSY) &&
                         (q.state != flash_ctrl_pkg::ST_BUSY);

    always_comb
    begin
        unique case (d.op)
            flash_ctrl_pkg::OP_PAGE_ERASE: timer_dur = 16'(PAGE_ERASE_US);
            flash_ctrl_pkg::OP_MASS_ERASE: timer_dur = 16'(MASS_ERASE_US);
            default:                       timer_dur = 16'(PROG_US);
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        d        = q;
        d.rvalid = 1'b0;
        d.cmd.rd = 1'b0;
        if (q.rd_pend)
        begin
            d.rd_pend = 1'b0;
            d.rvalid  = 1'b1;
            d.rdata   = q.rd_blank ? flash_ctrl_pkg::ERASED_BYTE : arr_rdata_in;
        end
        if (reg_take)
        begin
            unique case (reg_sel_in)
                flash_ctrl_pkg::SEL_KHZ_HIGH: d.khz[15:8] = reg_wdata_in;
                flash_ctrl_pkg::SEL_KHZ_LOW:  d.khz[7:0]  = reg_wdata_in;
                flash_ctrl_pkg::SEL_PAGE:
                begin
                    unique case (q.state)
                        flash_ctrl_pkg::ST_KEY_TWO:
                        begin
                            // second page write must repeat the first
                            d.state = (reg_wdata_in[3:0] == q.page) ?
                                      flash_ctrl_pkg::ST_UNLOCKED :
                                      flash_ctrl_pkg::ST_LOCKED;
                        end
                        flash_ctrl_pkg::ST_SECTOR_WR:
                        begin
                            // protection bits only ever set until reset
                            d.protect = q.protect | reg_wdata_in;
                            d.state   = flash_ctrl_pkg::ST_LOCKED;
                        end
                        default:
                        begin
                            d.page  = reg_wdata_in[3:0];
                            d.state = flash_ctrl_pkg::ST_PAGE_SET;
                        end
                    endcase
                end
                flash_ctrl_pkg::SEL_CONTROL:
                begin
                    d.state = flash_ctrl_pkg::ST_LOCKED;
                    unique case (q.state)
                        flash_ctrl_pkg::ST_LOCKED, flash_ctrl_pkg::ST_PAGE_SET:
                        begin
                            if (reg_wdata_in == flash_ctrl_pkg::CMD_KEY_FIRST)
                            begin
                                d.state = flash_ctrl_pkg::ST_KEY_ONE;
                            end
                        end
                        flash_ctrl_pkg::ST_KEY_ONE:
                        begin
                            if (reg_wdata_in == flash_ctrl_pkg::CMD_KEY_SECOND)
                            begin
                                d.state = flash_ctrl_pkg::ST_KEY_TWO;
                            end
                            else if (reg_wdata_in == flash_ctrl_pkg::CMD_KEY_SECTOR)
                            begin
                                d.state = flash_ctrl_pkg::ST_SECTOR_WR;
                            end
                        end
                        flash_ctrl_pkg::ST_UNLOCKED:
                        begin
                            if (reg_wdata_in == flash_ctrl_pkg::CMD_PAGE_ERASE && page_open)
                            begin
                                d.state              = flash_ctrl_pkg::ST_BUSY;
                                d.op                 = flash_ctrl_pkg::OP_PAGE_ERASE;
                                d.cmd.addr           = {3'b000, q.page, 9'h000};
                                d.cmd.info           = 1'b0;
                                d.cmd.page_erase     = 1'b1;
                            end
                            else if (reg_wdata_in == flash_ctrl_pkg::CMD_MASS_ERASE &&
                                     dbg_mode_in && khz_ok && (q.protect == 8'h00))
                            begin
                                // whole-array erase reachable only from the debugger
                                d.state              = flash_ctrl_pkg::ST_BUSY;
                                d.op                 = flash_ctrl_pkg::OP_MASS_ERASE;
                                d.cmd.mass_erase     = 1'b1;
                            end
                        end
                        default:
                        begin
                            d.state = flash_ctrl_pkg::ST_LOCKED;
                        end
                    endcase
                end
            endcase
        end
        else if (mem_take)
        begin
            d.cmd.addr   = mem_req_in.addr;
            d.cmd.row    = ainfo.row;
            d.cmd.info   = ainfo.in_info;
            d.cmd.option = ainfo.option;
            if (!mem_req_in.write)
            begin
                // holes between the two regions read as erased, no array access
                d.rd_pend  = 1'b1;
                d.rd_blank = !(ainfo.in_prog || ainfo.in_info);
                d.cmd.rd   = ainfo.in_prog || ainfo.in_info;
            end
            else if (q.state == flash_ctrl_pkg::ST_UNLOCKED && ainfo.in_prog &&
                     ainfo.page == q.page && page_open)
            begin
                // the cell only drops ones, so wdata zeros are what get programmed
                d.state     = flash_ctrl_pkg::ST_BUSY;
                d.op        = flash_ctrl_pkg::OP_PROG;
                d.cmd.wdata = mem_req_in.wdata;
                d.cmd.prog  = 1'b1;
            end
        end
        if (q.state == flash_ctrl_pkg::ST_BUSY && timer_done)
        begin
            d.cmd.prog       = 1'b0;
            d.cmd.page_erase = 1'b0;
            d.cmd.mass_erase = 1'b0;
            d.op             = flash_ctrl_pkg::OP_NONE;
            // a page stays open between byte writes; erases always relock
            d.state = (q.op == flash_ctrl_pkg::OP_PROG) ? flash_ctrl_pkg::ST_UNLOCKED :
                                                          flash_ctrl_pkg::ST_LOCKED;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            q         <= '0;
            q.state   <= flash_ctrl_pkg::ST_LOCKED;
            q.op      <= flash_ctrl_pkg::OP_NONE;
            q.khz     <= flash_ctrl_pkg::KHZ_RESET;
            q.protect <= flash_ctrl_pkg::PROTECT_RESET;
            q.page    <= flash_ctrl_pkg::PAGE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign mem_rvalid_out      = q.rvalid;
    assign mem_rdata_out       = q.rdata;
    assign flash_clock_khz_out = q.khz;
    assign locked_out          = (q.state != flash_ctrl_pkg::ST_UNLOCKED);
    assign busy_out            = (q.state == flash_ctrl_pkg::ST_BUSY);
    assign sector_protect_out  = q.protect;
    assign arr_cmd_out         = q.cmd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    logic page_wr;
    logic ctl_wr;
    assign page_wr = reg_take && reg_sel_in == flash_ctrl_pkg::SEL_PAGE;
    assign ctl_wr  = reg_take && reg_sel_in == flash_ctrl_pkg::SEL_CONTROL;

    AST_LOCKED_AFTER_RESET: assert property ($past(rst_in) |-> locked_out && !busy_out)
        else $error("not locked after reset");
    AST_PAGE_MISMATCH: assert property (
        (q.state == flash_ctrl_pkg::ST_KEY_TWO && page_wr && reg_wdata_in[3:0] != q.page)
        |=> q.state == flash_ctrl_pkg::ST_LOCKED)
        else $error("mismatched page did not relock");
    AST_KEY_ORDER: assert property (
        (q.state == flash_ctrl_pkg::ST_KEY_TWO && page_wr && reg_wdata_in[3:0] == q.page)
        |=> !locked_out)
        else $error("valid key sequence did not unlock");
    AST_ERASE_START: assert property (
        (q.state == flash_ctrl_pkg::ST_UNLOCKED && ctl_wr &&
        reg_wdata_in == flash_ctrl_pkg::CMD_PAGE_ERASE && page_open)
        |=> busy_out && arr_cmd_out.page_erase)
        else $error("page erase not started");
    AST_ERASE_PROTECTED: assert property (
        (q.state == flash_ctrl_pkg::ST_UNLOCKED && ctl_wr && q.protect[q.page[3:1]])
        |=> !arr_cmd_out.page_erase && locked_out)
        else $error("protected sector erased");
    AST_OTHER_RELOCKS: assert property (
        (q.state == flash_ctrl_pkg::ST_UNLOCKED && ctl_wr &&
        reg_wdata_in != flash_ctrl_pkg::CMD_PAGE_ERASE &&
        reg_wdata_in != flash_ctrl_pkg::CMD_MASS_ERASE) |=> q.state == flash_ctrl_pkg::ST_LOCKED)
        else $error("stray control write left page open");
    AST_KHZ_HIGH: assert property (
        (reg_take && reg_sel_in == flash_ctrl_pkg::SEL_KHZ_HIGH)
        |=> flash_clock_khz_out[15:8] == $past(reg_wdata_in))
        else $error("frequency high byte not loaded");
    AST_RATE_GATE: assert property (
        $rose(busy_out) |-> flash_clock_khz_out >= flash_ctrl_pkg::KHZ_MIN &&
        flash_clock_khz_out <= flash_ctrl_pkg::KHZ_MAX)
        else $error("operation started outside clock range");
    AST_PROG_IN_PAGE: assert property (
        $rose(arr_cmd_out.prog) |-> arr_cmd_out.addr[15:9] == {3'b000, q.page})
        else $error("byte programmed outside active page");
    AST_READ_LATENCY: assert property (
        (mem_take && !mem_req_in.write) |-> ##2 mem_rvalid_out)
        else $error("read answer not two cycles later");
    AST_PROTECT_STICKY: assert property (
        $past(q.protect) != 8'h00 |-> (q.protect & $past(q.protect)) == $past(q.protect))
        else $error("sector protection bit cleared");

    COV_UNLOCK: cover property ($fell(locked_out));
    COV_PAGE_ERASE: cover property ($rose(arr_cmd_out.page_erase));
    COV_PROG_DONE: cover property ($fell(arr_cmd_out.prog) ##1 !locked_out);

endmodule

// *** dv/flash_array_model.sv ***
// behavioural flash array answering the sequencer strobes
`timescale 1ns/10ps

module flash_array_model
(
    input  wire logic                        core_clk_in,
    input  wire flash_ctrl_pkg::arr_cmd_type cmd_in,
    output logic [7:0]                       rdata_out
);
    logic [7:0] mem [0:8191];
    logic       prog_q;
    logic       erase_q;

    // read data follows the address with no register, as the sequencer expects
    assign rdata_out = mem[cmd_in.addr[12:0]];

    initial
    begin
        prog_q = 1'b0;
        erase_q = 1'b0;
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'hFF;
    end

    // act on the rising strobe only; a long pulse must not repeat the action
    always @(posedge core_clk_in)
    begin
        prog_q <= cmd_in.prog;
        erase_q <= cmd_in.page_erase | cmd_in.mass_erase;
        if (cmd_in.prog && !prog_q)
            mem[cmd_in.addr[12:0]] <= mem[cmd_in.addr[12:0]] & cmd_in.wdata;
        if (cmd_in.page_erase && !erase_q)
            for (int i = 0; i < 512; i++)
                mem[{cmd_in.addr[12:9], i[8:0]}] <= 8'hFF;
        if (cmd_in.mass_erase && !erase_q)
            for (int i = 0; i < 8192; i++)
                mem[i] <= 8'hFF;
    end
endmodule

// *** dv/flash_array_timing_ctrl_tb_top.sv ***
// self-checking bench of the flash sequencer
`timescale 1ns/10ps

module flash_array_timing_ctrl_tb_top;
    logic                        core_clk_in;
    logic                        rst_in;
    logic                        reg_wr;
    flash_ctrl_pkg::reg_sel_type reg_sel;
    logic [7:0]                  reg_wdata;
    flash_ctrl_pkg::mem_req_type req;
    logic                        ready;
    logic                        rvalid;
    logic [7:0]                  rdata;
    logic [15:0]                 khz;
    logic                        locked;
    logic                        busy;
    logic [7:0]                  protect;
    flash_ctrl_pkg::arr_cmd_type cmd;
    logic [7:0]                  arr_rdata;
    logic                        dbg_mode;
    logic                        write_allow;
    int                          n_errors = 0;
    int                          check_count = 0;

    // short pulses keep the run brief; 20000 kHz gives 20 cycles per microsecond
    flash_array_timing_ctrl #(.PROG_US(1), .PAGE_ERASE_US(2), .MASS_ERASE_US(2)) uut
    (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_sel_in(reg_sel),
        .reg_wdata_in(reg_wdata), .dbg_mode_in(dbg_mode), .write_allow_in(write_allow),
        .mem_req_in(req),
        .mem_ready_out(ready), .mem_rvalid_out(rvalid), .mem_rdata_out(rdata),
        .flash_clock_khz_out(khz), .locked_out(locked), .busy_out(busy),
        .sector_protect_out(protect), .arr_cmd_out(cmd), .arr_rdata_in(arr_rdata)
    );
    flash_array_model array (.core_clk_in(core_clk_in), .cmd_in(cmd), .rdata_out(arr_rdata));

    initial
    begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input flash_ctrl_pkg::reg_sel_type s, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_wr = 1'b1;
        reg_sel = s;
        reg_wdata = d;
        @(negedge core_clk_in);
        reg_wr = 1'b0;
    endtask

    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          input logic [7:0] exp);
        int n;
        @(negedge core_clk_in);
        req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        for (n = 0; n < 100 && ready !== 1'b1; n++)
            @(negedge core_clk_in);
        chk({15'h0000, ready}, 16'h0001);
        @(negedge core_clk_in);
        req.valid = 1'b0;
        if (!wr)
        begin
            @(negedge core_clk_in);
            chk({8'h00, rdata}, {8'h00, exp});
            chk({15'h0000, rvalid}, 16'h0001);
        end
    endtask

    // exp: busy cycles still seen, 20 per microsecond plus one for the done flag
    task automatic wait_idle(input int exp);
        int n;
        for (n = 0; n < 2000 && busy !== 1'b0; n++)
            @(negedge core_clk_in);
        chk({15'h0000, busy}, 16'h0000);
        chk(n[15:0], exp[15:0]);
    endtask

    task automatic unlock(input logic [7:0] p1, input logic [7:0] p2);
        wreg(flash_ctrl_pkg::SEL_PAGE, p1);
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_KEY_FIRST);
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_KEY_SECOND);
        wreg(flash_ctrl_pkg::SEL_PAGE, p2);
        @(negedge core_clk_in);
    endtask

    task automatic test_reset_and_khz();
        chk({locked, busy, protect, 6'h00}, 16'h8000);
        chk(khz, flash_ctrl_pkg::KHZ_RESET);
        wreg(flash_ctrl_pkg::SEL_KHZ_LOW, 8'h20);
        wreg(flash_ctrl_pkg::SEL_KHZ_HIGH, 8'h4E);
        @(negedge core_clk_in);
        chk(khz, 16'h4E20);
        $display("test reset_and_khz done");
    endtask

    task automatic test_unlock_program();
        access(1'b1, 16'h0204, 8'h00, 8'h00);
        wait_idle(0);
        access(1'b0, 16'h0204, 8'h00, 8'hFF);
        unlock(8'h01, 8'h02);
        chk({15'h0000, locked}, 16'h0001);
        unlock(8'h01, 8'h01);
        chk({15'h0000, locked}, 16'h0000);
        access(1'b1, 16'h0204, 8'h5A, 8'h00);
        wait_idle(21);
        access(1'b1, 16'h0204, 8'hF0, 8'h00);
        wait_idle(21);
        chk({15'h0000, locked}, 16'h0000);
        access(1'b0, 16'h0204, 8'h00, 8'h50);
        access(1'b0, 16'h3000, 8'h00, 8'hFF);
        $display("test unlock_program done");
    endtask

    task automatic test_erase_relock();
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_PAGE_ERASE);
        @(negedge core_clk_in);
        chk({15'h0000, busy}, 16'h0001);
        wait_idle(40);
        chk({15'h0000, locked}, 16'h0001);
        access(1'b0, 16'h0204, 8'h00, 8'hFF);
        unlock(8'h03, 8'h03);
        wreg(flash_ctrl_pkg::SEL_CONTROL, 8'h11);
        @(negedge core_clk_in);
        chk({15'h0000, locked}, 16'h0001);
        $display("test erase_relock done");
    endtask

    // mass erase must precede protection: it is refused once any sector is protected
    task automatic test_mass_protect();
        unlock(8'h05, 8'h05);
        access(1'b1, 16'h0A10, 8'h3C, 8'h00);
        wait_idle(21);
        dbg_mode = 1'b1;
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_MASS_ERASE);
        wait_idle(41);
        dbg_mode = 1'b0;
        access(1'b0, 16'h0A10, 8'h00, 8'hFF);
        access(1'b0, 16'hFE41, 8'h00, 8'hFF);
        chk({11'h000, cmd.row, cmd.info, cmd.option}, 16'h0006);
        access(1'b0, 16'h0001, 8'h00, 8'hFF);
        chk({11'h000, cmd.row, cmd.info, cmd.option}, 16'h0001);
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_KEY_FIRST);
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_KEY_SECTOR);
        wreg(flash_ctrl_pkg::SEL_PAGE, 8'h04);
        @(negedge core_clk_in);
        chk({8'h00, protect}, 16'h0004);
        unlock(8'h05, 8'h05);
        access(1'b1, 16'h0A10, 8'h00, 8'h00);
        wait_idle(0);
        wreg(flash_ctrl_pkg::SEL_CONTROL, flash_ctrl_pkg::CMD_PAGE_ERASE);
        wait_idle(0);
        chk({15'h0000, locked}, 16'h0001);
        write_allow = 1'b0;
        unlock(8'h06, 8'h06);
        access(1'b1, 16'h0C00, 8'h00, 8'h00);
        wait_idle(0);
        write_allow = 1'b1;
        wreg(flash_ctrl_pkg::SEL_KHZ_HIGH, 8'h60);
        access(1'b1, 16'h0C00, 8'h00, 8'h00);
        wait_idle(0);
        wreg(flash_ctrl_pkg::SEL_KHZ_HIGH, 8'h4E);
        $display("test mass_protect done");
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        rst_in = 1'b1;
        reg_wr = 1'b0;
        reg_sel = flash_ctrl_pkg::SEL_CONTROL;
        reg_wdata = 8'h00;
        req = '0;
        dbg_mode = 1'b0;
        write_allow = 1'b1;
        repeat (5) @(negedge core_clk_in);
        rst_in = 1'b0;
        test_reset_and_khz();
        test_unlock_program();
        test_erase_relock();
        test_mass_protect();
        print_verdict();
    end

    // the tests need well under 2000 cycles; this bounds a hang
    initial
    begin
        #50000;
        n_errors++;
        print_verdict();
    end
endmodule
